// file: inc/icu_pkg.sv
package icu_pkg;
  // register indexes (printed offsets are not all word aligned, kept as indexes)
  localparam logic [7:0] IDX_VECTOR = 8'h00;
  localparam logic [7:0] IDX_NMI_STAT = 8'h02;
  localparam logic [7:0] IDX_NMI_CTRL = 8'h04;
  localparam logic [7:0] IDX_RAW_LOW = 8'h0A;
  localparam logic [7:0] IDX_RAW_HIGH = 8'h0C;
  localparam logic [7:0] IDX_MASK_LOW = 8'h0E;
  localparam logic [7:0] IDX_MASK_HIGH = 8'h10;
  localparam int ADDR_W = 10;
  // trap control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_PIN = 1;
  localparam int CTRL_LCK = 2;
  localparam int STAT_EXT = 0;
  // reset values
  localparam logic [15:0] MASK_RST = 16'hFFFF;
  localparam logic [5:0] VEC_BASE = 6'h10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int NUM_IRQ = 32;

  // request bundle toward the core
  typedef struct packed {
    logic nmi;
    logic irq;
    logic [7:0] vector;
  } icu_core_req_t;

  // slave handshake state
  typedef enum logic [1:0] {
    ICU_IDLE = 2'b00,
    ICU_RESP = 2'b01
  } icu_bus_st_t;
endpackage

// file: rtl/icu_prio_enc.sv
`timescale 1ns/100ps
// priority encoder: highest set bit wins, bit 0 never considered
module icu_prio_enc #(
  parameter int N = 32
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [5:0] num
);
  // scan upward so the highest index overwrites lower ones
  always_comb begin
    any = 1'b0;
    num = 6'h00;
    for (int i = 1; i < N; i++) begin
      if (req[i]) begin
        any = 1'b1;
        num = 6'(i);
      end
    end
  end
endmodule

// file: rtl/icu_top.sv
`timescale 1ns/100ps
// Overview of operation
// - nmi status byte resets to zero and clears on every read except one in the same cycle as a capture
// - status bit 0 reads one once an external nmi request is captured
// - reset clears test, trap enable and lock bits
// - falling nmi edge makes a trap request while enable or lock set
// - trap enable clears at reset and whenever the request flag sets
// - writing one to enable works only while request flag is clear
// - trap control bit 1 mirrors nmi level, writes ignored
// - lock bit, once set, stays set until reset
// - lock set enables nmi regardless of trap enable
// - vector bits 5..0 encode winner, range 10h..2Fh, bits 7..6 zero
// - vector stays stable except while updating
// - low mask enables requests 1..15, resets to FFFFh
// - low mask bit 0 has no effect
// - high mask enables requests 16..31, resets to FFFFh
// - low raw word shows requests 15..1, bit 0 reads zero
// - high raw word shows requests 31..16 unmasked
// - priority is linear, request 31 highest, request 1 lowest
// - nmi pre-empts anything; maskable nesting left to core enable
// - maskable requests are levels, pending only while held
// - nmi pin is synchronised before edge detection
module icu_top (
  input wire logic core_clk,
  input wire logic resetn,
  // axi4-lite slave
  input wire logic [icu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [icu_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sources and core side
  input wire logic nmi_n_pin,
  input wire logic [31:0] irq_src,
  output icu_pkg::icu_core_req_t core_req
);

  // ----------------------------------------
  // address decode helper
  // ----------------------------------------
  // byte address is four times the printed index
  function automatic logic addr_is(input logic [icu_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    addr_is = (a == {idx, 2'b00});
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic nmi_s1_q, nmi_s2_q, nmi_s3_q;
  logic ext_q, ext_d;
  logic en_q, en_d;
  logic lck_q, lck_d;
  logic tst_q, tst_d;
  logic [15:0] mask_lo_q, mask_hi_q;
  logic [31:0] src_q;
  logic [5:0] vec_q;
  logic nmi_req_q, irq_q;
  icu_pkg::icu_bus_st_t wst_q, rst_q;
  logic aw_got_q, w_got_q;
  logic [icu_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // ----------------------------------------
  // nmi pin synchroniser and edge detect
  // ----------------------------------------
  // sync before edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      nmi_s1_q <= 1'b1;
      nmi_s2_q <= 1'b1;
      nmi_s3_q <= 1'b1;
    end else begin
      nmi_s1_q <= nmi_n_pin;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  wire nmi_fall = nmi_s3_q & ~nmi_s2_q;
  wire nmi_armed = en_q | lck_q;
  wire nmi_take = nmi_fall & nmi_armed;
  wire pin_level = ~nmi_s2_q;

  // ----------------------------------------
  // bus write channel
  // ----------------------------------------
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_got_q | aw_hs;
  wire w_have = w_got_q | w_hs;
  wire wr_fire = (wst_q == icu_pkg::ICU_IDLE) & aw_have & w_have;
  wire [icu_pkg::ADDR_W-1:0] wa = aw_hs ? s_axi_awaddr : awaddr_q;
  wire [31:0] wd = w_hs ? s_axi_wdata : wdata_q;
  wire [3:0] ws = w_hs ? s_axi_wstrb : wstrb_q;
  wire wr_ctrl = wr_fire & addr_is(wa, icu_pkg::IDX_NMI_CTRL) & ws[0];
  wire wr_mlo = wr_fire & addr_is(wa, icu_pkg::IDX_MASK_LOW);
  wire wr_mhi = wr_fire & addr_is(wa, icu_pkg::IDX_MASK_HIGH);
  wire wa_known = addr_is(wa, icu_pkg::IDX_VECTOR) | addr_is(wa, icu_pkg::IDX_NMI_STAT)
    | addr_is(wa, icu_pkg::IDX_NMI_CTRL) | addr_is(wa, icu_pkg::IDX_RAW_LOW)
    | addr_is(wa, icu_pkg::IDX_RAW_HIGH) | addr_is(wa, icu_pkg::IDX_MASK_LOW)
    | addr_is(wa, icu_pkg::IDX_MASK_HIGH);

  // one-deep capture of address and data, taken in either order
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      bresp_q <= icu_pkg::RESP_OKAY;
      wst_q <= icu_pkg::ICU_IDLE;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      case (wst_q)
        icu_pkg::ICU_IDLE: begin
          if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            bresp_q <= wa_known ? icu_pkg::RESP_OKAY : icu_pkg::RESP_SLVERR;
            wst_q <= icu_pkg::ICU_RESP;
          end else begin
            aw_got_q <= aw_have;
            w_got_q <= w_have;
            s_axi_awready <= ~aw_have;
            s_axi_wready <= ~w_have;
          end
        end
        default: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wst_q <= icu_pkg::ICU_IDLE;
          end
        end
      endcase
    end
  end
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------
  // bus read channel
  // ----------------------------------------
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire rd_stat = ar_hs & addr_is(s_axi_araddr, icu_pkg::IDX_NMI_STAT);
  // bit 0 forced zero, raw upper word
  wire [15:0] raw_lo = {src_q[15:1], 1'b0};
  wire [15:0] raw_hi = src_q[31:16];
  wire [7:0] ctrl_rd = {5'b00000, lck_q, pin_level, en_q};
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    if (addr_is(s_axi_araddr, icu_pkg::IDX_VECTOR)) begin
      rd_mux = {26'h000_0000, vec_q};
    end else if (addr_is(s_axi_araddr, icu_pkg::IDX_NMI_STAT)) begin
      rd_mux = {31'h0000_0000, ext_q};
    end else if (addr_is(s_axi_araddr, icu_pkg::IDX_NMI_CTRL)) begin
      rd_mux = {24'h00_0000, ctrl_rd};
    end else if (addr_is(s_axi_araddr, icu_pkg::IDX_RAW_LOW)) begin
      rd_mux = {16'h0000, raw_lo};
    end else if (addr_is(s_axi_araddr, icu_pkg::IDX_RAW_HIGH)) begin
      rd_mux = {16'h0000, raw_hi};
    end else if (addr_is(s_axi_araddr, icu_pkg::IDX_MASK_LOW)) begin
      rd_mux = {16'h0000, mask_lo_q};
    end else if (addr_is(s_axi_araddr, icu_pkg::IDX_MASK_HIGH)) begin
      rd_mux = {16'h0000, mask_hi_q};
    end else begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b0;
    end
  end

  // read data captured at address acceptance, answer next cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= icu_pkg::RESP_OKAY;
      rst_q <= icu_pkg::ICU_IDLE;
    end else begin
      case (rst_q)
        icu_pkg::ICU_IDLE: begin
          s_axi_arready <= ~ar_hs;
          if (ar_hs) begin
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? icu_pkg::RESP_OKAY : icu_pkg::RESP_SLVERR;
            s_axi_rvalid <= 1'b1;
            rst_q <= icu_pkg::ICU_RESP;
          end
        end
        default: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rst_q <= icu_pkg::ICU_IDLE;
          end
        end
      endcase
    end
  end
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // nmi status and trap control
  // ----------------------------------------
  // capture wins over clear-on-read so no event is lost
  assign ext_d = nmi_take ? 1'b1 : (rd_stat ? 1'b0 : ext_q);
  // hardware clear on capture, set only while flag clear
  always_comb begin
    en_d = en_q;
    if (wr_ctrl) begin
      en_d = wd[icu_pkg::CTRL_EN] ? (en_q | ~ext_q) : 1'b0;
    end
    if (nmi_take) begin
      en_d = 1'b0;
    end
  end
  // lock is set-only; pin bit not writable
  assign lck_d = lck_q | (wr_ctrl & wd[icu_pkg::CTRL_LCK]);
  // reserved bits discarded; test bit held clear
  assign tst_d = 1'b0;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ext_q <= 1'b0;
      en_q <= 1'b0;
      lck_q <= 1'b0;
      tst_q <= 1'b0;
    end else begin
      ext_q <= ext_d;
      en_q <= en_d;
      lck_q <= lck_d;
      tst_q <= tst_d;
    end
  end

  // ----------------------------------------
  // masks, sources, vector
  // ----------------------------------------
  // masks reset to all ones, byte lanes honoured
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mask_lo_q <= icu_pkg::MASK_RST;
      mask_hi_q <= icu_pkg::MASK_RST;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wr_mlo && ws[b]) begin
          mask_lo_q[b*8 +: 8] <= wd[b*8 +: 8];
        end
        if (wr_mhi && ws[b]) begin
          mask_hi_q[b*8 +: 8] <= wd[b*8 +: 8];
        end
      end
    end
  end

  // bit 0 of both source and mask excluded
  wire [31:0] pend = {src_q[31:1] & {mask_hi_q, mask_lo_q[15:1]}, 1'b0};
  logic any_pend;
  logic [5:0] win;

  icu_prio_enc #(.N(icu_pkg::NUM_IRQ)) u_enc (
    .req(pend),
    .any(any_pend),
    .num(win)
  );

  // levels sampled each cycle, no latching; vector registered
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      src_q <= 32'h0000_0000;
      vec_q <= icu_pkg::VEC_BASE;
      irq_q <= 1'b0;
      nmi_req_q <= 1'b0;
    end else begin
      src_q <= irq_src;
      vec_q <= icu_pkg::VEC_BASE + win;
      irq_q <= any_pend;
      // nmi pulse independent of maskable state
      nmi_req_q <= nmi_take;
    end
  end

  assign core_req = '{nmi: nmi_req_q, irq: irq_q, vector: {2'b00, vec_q}};

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_stat_clear;
    @(posedge core_clk) disable iff (!resetn) (rd_stat && !nmi_take) |=> !ext_q;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");
  property p_ext_set;
    @(posedge core_clk) disable iff (!resetn) nmi_take |=> ext_q && core_req.nmi;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("nmi capture missing");
  property p_no_trap;
    @(posedge core_clk) disable iff (!resetn) !(en_q || lck_q) |=> !core_req.nmi;
  endproperty
  a_no_trap: assert property (p_no_trap) else $error("nmi while disabled");
  property p_en_clear;
    @(posedge core_clk) disable iff (!resetn) $rose(ext_q) |-> !en_q;
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("enable not cleared");
  property p_en_block;
    @(posedge core_clk) disable iff (!resetn) (ext_q && !en_q) |=> !en_q;
  endproperty
  a_en_block: assert property (p_en_block) else $error("enable set while flag set");
  property p_lock;
    @(posedge core_clk) disable iff (!resetn) lck_q |=> lck_q [*8];
  endproperty
  a_lock: assert property (p_lock) else $error("lock dropped");
  property p_vec_range;
    @(posedge core_clk) disable iff (!resetn) core_req.vector >= 8'h10 && core_req.vector <= 8'h2F;
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector out of range");
  property p_irq;
    @(posedge core_clk) disable iff (!resetn) ##1 core_req.irq == $past(|pend);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_top;
    @(posedge core_clk) disable iff (!resetn) pend[31] |=> core_req.vector == 8'h2F;
  endproperty
  a_top: assert property (p_top) else $error("priority wrong");

  c_nmi: cover property (@(posedge core_clk) disable iff (!resetn) nmi_take);
  c_lock_nmi: cover property (@(posedge core_clk) disable iff (!resetn) lck_q && !en_q && nmi_take);
  c_stat_rd: cover property (@(posedge core_clk) disable iff (!resetn) rd_stat && ext_q);
  c_irq: cover property (@(posedge core_clk) disable iff (!resetn) core_req.irq);
endmodule

// file: dv/icu_far_model.sv
`timescale 1ns/100ps
// far side: peripheral request flops and the core's trap intake
module icu_far_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [31:0] irq_cmd,
  input wire logic nmi_cmd,
  input wire icu_pkg::icu_core_req_t core_req,
  output logic [31:0] irq_src,
  output logic nmi_n_pin,
  output logic [7:0] nmi_cnt
);
  // pin idles high as if pulled up; requests start inactive
  initial begin
    irq_src = '0;
    nmi_n_pin = 1'b1;
    nmi_cnt = 8'h00;
  end
  // sources hold a request as a level until told to drop it
  // level requests
  always @(posedge core_clk) begin
    irq_src <= irq_cmd;
    nmi_n_pin <= nmi_cmd;
  end
  // the core takes one trap per request pulse
  always @(posedge core_clk) begin
    if (!resetn) nmi_cnt <= 8'h00;
    else if (core_req.nmi) nmi_cnt <= nmi_cnt + 8'h01;
  end
endmodule

// file: dv/tb.sv
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [icu_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [icu_pkg::ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic nmi_n_pin;
  logic [31:0] irq_src;
  icu_pkg::icu_core_req_t core_req;
  logic [31:0] irq_cmd = '0;
  logic nmi_cmd = 1'b1;
  logic [7:0] nmi_cnt;
  logic [31:0] d;
  logic [1:0] r;
  int n_fail = 0;
  int num_checks = 0;
  int n;

  always #2.5 core_clk = ~core_clk;

  icu_top i_icu_top (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_n_pin, .irq_src, .core_req);
  icu_far_model i_icu_far_model (.core_clk, .resetn, .irq_cmd, .nmi_cmd, .core_req,
    .irq_src, .nmi_n_pin, .nmi_cnt);

  // ----------------------------------------
  // bus tasks and compares
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task timeout_hit;
    n_fail++;
    $display("[ERR] %0t wait timed out", $time);
    report_and_stop();
  endtask
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t response %b expected %b", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // address and data offered together, each dropped once taken
  task axi_wr(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] rsp);
    int i;
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && (aw_p || w_p); i++) begin
      @(posedge core_clk);
      if (aw_p && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    if (aw_p || w_p) timeout_hit();
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) @(posedge core_clk);
    if (i == 50) timeout_hit();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rsp);
    int i;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // let an edge pass first: the ready seen now is the previous cycle's value
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) break;
    end
    if (i == 50) timeout_hit();
    s_axi_arvalid <= 1'b0;
    // sampling happens before this edge's updates land, so rvalid is the handshake value
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (s_axi_rvalid === 1'b1) break;
    end
    if (i == 50) timeout_hit();
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] v);
    axi_wr(idx, v, r);
    chk_resp(r, icu_pkg::RESP_OKAY);
  endtask
  task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    axi_rd(idx, d, r);
    chk_resp(r, icu_pkg::RESP_OKAY);
    chk_val(d, exp);
  endtask
  // low pulse on the pin, long enough to pass the synchroniser
  task nmi_pulse;
    nmi_cmd <= 1'b0;
    cyc(8);
    nmi_cmd <= 1'b1;
    cyc(8);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(2);
    resetn <= 1'b1;
    cyc(1);
    rd_chk(icu_pkg::IDX_MASK_LOW, {16'h0000, icu_pkg::MASK_RST});
    rd_chk(icu_pkg::IDX_MASK_HIGH, {16'h0000, icu_pkg::MASK_RST});
    rd_chk(icu_pkg::IDX_NMI_STAT, 32'h0000_0000);
    rd_chk(icu_pkg::IDX_NMI_CTRL, 32'h0000_0000);
    rd_chk(icu_pkg::IDX_VECTOR, 32'h0000_0010);
    // unmapped place and a write to the read-only vector
    axi_rd(8'hF0, d, r);
    chk_resp(r, icu_pkg::RESP_SLVERR);
    chk_val(d, 32'h0000_0000);
    axi_wr(8'hF0, 32'hFFFF_FFFF, r);
    chk_resp(r, icu_pkg::RESP_SLVERR);
    wr(icu_pkg::IDX_VECTOR, 32'h0000_003F);
    rd_chk(icu_pkg::IDX_VECTOR, 32'h0000_0010);
    // winner walks up while request 1 and the dead line 0 stay asserted
    for (n = 1; n < 32; n++) begin
      irq_cmd <= (32'h0000_0001 << n) | 32'h0000_0003;
      cyc(4);
      chk_val({22'h0, core_req}, 32'h0000_0110 + n);
      rd_chk(icu_pkg::IDX_VECTOR, 32'h0000_0010 + n);
    end
    irq_cmd <= 32'h8000_8003;
    wr(icu_pkg::IDX_MASK_HIGH, 32'h0000_0000);
    cyc(4);
    rd_chk(icu_pkg::IDX_RAW_HIGH, 32'h0000_8000);
    rd_chk(icu_pkg::IDX_RAW_LOW, 32'h0000_8002);
    chk_val({22'h0, core_req}, 32'h0000_011F);
    wr(icu_pkg::IDX_MASK_LOW, 32'h0000_7FFF);
    cyc(4);
    chk_val({22'h0, core_req}, 32'h0000_0111);
    wr(icu_pkg::IDX_MASK_LOW, 32'h0000_0001);
    cyc(4);
    chk_val({22'h0, core_req}, 32'h0000_0010);
    rd_chk(icu_pkg::IDX_MASK_LOW, 32'h0000_0001);
    wr(icu_pkg::IDX_MASK_LOW, 32'h0000_FFFF);
    wr(icu_pkg::IDX_MASK_HIGH, 32'h0000_FFFF);
    cyc(4);
    chk_val({22'h0, core_req}, 32'h0000_012F);
    irq_cmd <= 32'h0000_0000;
    cyc(4);
    chk_val({22'h0, core_req}, 32'h0000_0010);
    // non-maskable path: disarmed, armed once, then locked
    nmi_cmd <= 1'b0;
    cyc(8);
    rd_chk(icu_pkg::IDX_NMI_CTRL, 32'h0000_0002);
    nmi_cmd <= 1'b1;
    cyc(8);
    chk_val({24'h0, nmi_cnt}, 32'h0000_0000);
    rd_chk(icu_pkg::IDX_NMI_STAT, 32'h0000_0000);
    wr(icu_pkg::IDX_NMI_CTRL, 32'h0000_0003);
    rd_chk(icu_pkg::IDX_NMI_CTRL, 32'h0000_0001);
    nmi_pulse();
    chk_val({24'h0, nmi_cnt}, 32'h0000_0001);
    rd_chk(icu_pkg::IDX_NMI_CTRL, 32'h0000_0000);
    wr(icu_pkg::IDX_NMI_CTRL, 32'h0000_0001);
    rd_chk(icu_pkg::IDX_NMI_CTRL, 32'h0000_0000);
    rd_chk(icu_pkg::IDX_NMI_STAT, 32'h0000_0001);
    rd_chk(icu_pkg::IDX_NMI_STAT, 32'h0000_0000);
    wr(icu_pkg::IDX_NMI_CTRL, 32'h0000_0001);
    rd_chk(icu_pkg::IDX_NMI_CTRL, 32'h0000_0001);
    wr(icu_pkg::IDX_NMI_CTRL, 32'h0000_0000);
    rd_chk(icu_pkg::IDX_NMI_CTRL, 32'h0000_0000);
    wr(icu_pkg::IDX_NMI_CTRL, 32'h0000_0004);
    wr(icu_pkg::IDX_NMI_CTRL, 32'h0000_0000);
    rd_chk(icu_pkg::IDX_NMI_CTRL, 32'h0000_0004);
    nmi_pulse();
    nmi_pulse();
    chk_val({24'h0, nmi_cnt}, 32'h0000_0003);
    rd_chk(icu_pkg::IDX_NMI_CTRL, 32'h0000_0004);
    report_and_stop();
  end

  // whole-run guard against a hang outside the bounded waits
  initial begin
    #100000;
    timeout_hit();
  end
endmodule
